// *** serial_peer.sv ***
// Far-side serial peer: line loopback, forced break and slave transfer clock
module serial_peer (
    input  wire logic clk, line_from_dut, loop_en, hold_low, xck_run, xck_idle,
    output logic      line_to_dut, xck_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] div_q;
    logic       xck_q;
    // Pulled-up line: relays the frame back, or holds a break when told to
    assign line_to_dut = hold_low ? 1'b0 : (loop_en ? line_from_dut : 1'b1);
    // Period of 10 system cycles keeps margin under the quarter-rate ceiling; still when idle
    always @(posedge clk) begin
        div_q <= (div_q == 3'h4 || !xck_run) ? 3'h0 : div_q + 3'h1;
        if (!xck_run)
            xck_q <= xck_idle;
        else if (div_q == 3'h4)
            xck_q <= ~xck_q;
    end
    assign xck_line = xck_q;
endmodule

// *** test_usart_tx_clocking.sv ***
// Self-checking bench for the serial port clocking and frame transmit block
module test_usart_tx_clocking;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, reset_n, clk_en, sync_mode_select, double_speed_bit, xck_direction_bit;
    logic        clock_polarity_bit, stop_bit_select, tx_enable_bit, tx_ninth_bit, baud_low_write;
    logic        data_write, tx_complete_clear, loop_en, hold_low, xck_run;
    logic [2:0]  char_size_field;
    logic [1:0]  parity_mode_field;
    logic [11:0] baud_divisor;
    logic [7:0]  data_in;
    logic [8:0]  rx_got;
    wire         serial_in_pin, xck_in, serial_out_pin, serial_out_enable, xck_out, xck_out_enable;
    wire         data_empty_flag, tx_complete_flag, rx_complete_pulse, frame_error_flag, parity_error_flag;
    wire [8:0]   rx_data;
    wire         xline = xck_out_enable ? xck_out : xck_in;
    int          err_total, cmp_count, cycles, bitc;
    usart_tx_clocking u_dut (.clk, .reset_n, .clk_en, .sync_mode_select, .double_speed_bit, .xck_direction_bit,
        .clock_polarity_bit, .char_size_field, .parity_mode_field, .stop_bit_select, .tx_enable_bit,
        .tx_ninth_bit, .baud_divisor, .baud_low_write, .data_write, .data_in, .tx_complete_clear,
        .serial_in_pin, .xck_in, .serial_out_pin, .serial_out_enable, .xck_out, .xck_out_enable,
        .data_empty_flag, .tx_complete_flag, .rx_data, .rx_complete_pulse, .frame_error_flag,
        .parity_error_flag);
    serial_peer u_peer (.clk, .line_from_dut(serial_out_pin), .loop_en, .hold_low, .xck_run,
        .xck_idle(clock_polarity_bit), .line_to_dut(serial_in_pin), .xck_line(xck_in));
    // ****************************************
    // Clock, watchdog and receive capture
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // A hang counts as a mismatch
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 50000) begin
            err_total++;
            wrap_up();
        end
    end
    always @(posedge clk)
        if (rx_complete_pulse === 1'b1)
            rx_got <= rx_data;
    task automatic wrap_up();
        if (err_total == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // Sampling just after the edge keeps clear of the update race
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Async: one bit time; sync: next sampling edge of the transfer clock
    task automatic get_bit(output logic b);
        int k;
        k = 0;
        if (sync_mode_select) begin
            while (xline === clock_polarity_bit && k < 64) begin
                tick(1);
                k++;
            end
            while (xline !== clock_polarity_bit && k < 64) begin
                tick(1);
                k++;
            end
        end else begin
            tick(bitc);
        end
        b = serial_out_pin;
    endtask
    task automatic put(input logic [8:0] d);
        @(posedge clk);
        tx_complete_clear <= 1'b1;
        @(posedge clk);
        tx_complete_clear <= 1'b0;
        data_write <= 1'b1;
        {tx_ninth_bit, data_in} <= d;
        @(posedge clk);
        data_write <= 1'b0;
        #1;
    endtask
    task automatic grab(input logic [8:0] e, input int n, input logic [1:0] par, input logic stp, input logic last);
        int k;
        logic b;
        logic [8:0] got;
        k = 0;
        b = 1'b1;
        got = 9'h000;
        while (b !== 1'b0 && k < 400) begin
            if (sync_mode_select) begin
                get_bit(b);
            end else begin
                tick(1);
                b = serial_out_pin;
            end
            k++;
        end
        if (!sync_mode_select)
            tick(bitc / 2);
        chk({8'h00, serial_out_pin}, 9'h000);
        for (k = 0; k < n; k++) begin
            get_bit(b);
            got[k] = b;
        end
        chk(got, e);
        if (par[1]) begin
            get_bit(b);
            chk({8'h00, b}, {8'h00, ^e ^ par[0]});
        end
        for (k = 0; k <= stp; k++) begin
            get_bit(b);
            chk({8'h00, b}, 9'h001);
        end
        chk({8'h00, tx_complete_flag}, 9'h000);
        if (last) begin
            tick(bitc / 2 + 6);
            chk({8'h00, tx_complete_flag}, 9'h001);
            chk(rx_got, e);
            chk({7'h00, parity_error_flag, frame_error_flag}, 9'h000);
        end
    endtask
    task automatic frame(input logic [8:0] d, input logic [2:0] sz, input logic [1:0] par, input logic stp);
        int n;
        n = (sz == 3'h7) ? 9 : sz + 5;
        @(posedge clk);
        char_size_field <= sz;
        parity_mode_field <= par;
        stop_bit_select <= stp;
        put(d);
        grab(d & ((9'h001 << n) - 9'h001), n, par, stp, 1'b1);
    endtask
    task automatic s_formats();
        logic [2:0] sz [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        for (int s = 0; s < 5; s++)
            for (int p = 0; p < 4; p++)
                for (int t = 0; t < 2; t++)
                    frame(9'(9'h1a5 ^ (s * 37 + p * 5 + t)), sz[s], p[1:0], t[0]);
    endtask
    task automatic s_double();
        @(posedge clk);
        double_speed_bit <= 1'b1;
        bitc = 16;
        frame(9'h0c3, 3'h3, 2'h2, 1'b0);
        frame(9'h1ff, 3'h7, 2'h3, 1'b1);
        @(posedge clk);
        double_speed_bit <= 1'b0;
        bitc = 32;
    endtask
    // Second write lands while the first frame shifts: no idle gap allowed
    task automatic s_b2b();
        int k;
        @(posedge clk);
        char_size_field <= 3'h3;
        parity_mode_field <= 2'h0;
        stop_bit_select <= 1'b0;
        put(9'h03c);
        for (k = 0; k < 400 && data_empty_flag !== 1'b1; k++)
            tick(1);
        put(9'h0e1);
        chk({8'h00, data_empty_flag}, 9'h000);
        grab(9'h03c, 8, 2'h0, 1'b0, 1'b0);
        tick(bitc / 2 + 1);
        chk({8'h00, serial_out_pin}, 9'h000);
        grab(9'h0e1, 8, 2'h0, 1'b0, 1'b1);
    endtask
    task automatic s_hold();
        @(posedge clk);
        tx_enable_bit <= 1'b0;
        tick(4);
        chk({8'h00, serial_out_enable}, 9'h000);
        put(9'h05a);
        tick(3 * bitc);
        // Pending data keeps the pin owned although sending is held off
        chk({6'h00, serial_out_enable, serial_out_pin, data_empty_flag}, 9'h006);
        @(posedge clk);
        tx_enable_bit <= 1'b1;
        grab(9'h05a, 8, 2'h0, 1'b0, 1'b1);
    endtask
    task automatic s_break();
        int k;
        @(posedge clk);
        hold_low <= 1'b1;
        for (k = 0; k < 1000 && rx_complete_pulse !== 1'b1; k++)
            tick(1);
        tick(1);
        chk({8'h00, frame_error_flag}, 9'h001);
        chk(rx_got, 9'h000);
        @(posedge clk);
        hold_low <= 1'b0;
        tick(14 * bitc);
    endtask
    task automatic s_master();
        int k, p;
        logic b;
        @(posedge clk);
        sync_mode_select <= 1'b1;
        xck_direction_bit <= 1'b1;
        double_speed_bit <= 1'b1;
        baud_divisor <= 12'h003;
        baud_low_write <= 1'b1;
        @(posedge clk);
        baud_low_write <= 1'b0;
        bitc = 8;
        tick(12);
        chk({8'h00, xck_out_enable}, 9'h001);
        k = 0;
        for (p = 0; p < 32; p++) begin
            b = xck_out;
            tick(1);
            k += (xck_out !== b) ? 1 : 0;
        end
        chk(9'(k), 9'h008);
        for (p = 0; p < 2; p++) begin
            @(posedge clk);
            clock_polarity_bit <= p[0];
            tick(4);
            frame(9'(9'h0b6 + p), 3'h3, 2'h2, 1'b0);
        end
    endtask
    task automatic s_slave();
        @(posedge clk);
        xck_direction_bit <= 1'b0;
        double_speed_bit <= 1'b0;
        clock_polarity_bit <= 1'b0;
        xck_run <= 1'b1;
        bitc = 10;
        tick(12);
        chk({8'h00, xck_out_enable}, 9'h000);
        frame(9'h1c6, 3'h7, 2'h3, 1'b1);
        @(posedge clk);
        xck_run <= 1'b0;
        sync_mode_select <= 1'b0;
    endtask
    initial begin
        {reset_n, sync_mode_select, double_speed_bit, xck_direction_bit, clock_polarity_bit} = 5'h00;
        {stop_bit_select, tx_ninth_bit, baud_low_write, data_write, tx_complete_clear, hold_low, xck_run} = 7'h00;
        {clk_en, tx_enable_bit, loop_en} = 3'h7;
        char_size_field = 3'h3;
        parity_mode_field = 2'h0;
        baud_divisor = 12'h001;
        data_in = 8'h00;
        bitc = 32;
        repeat (8) @(posedge clk);
        #1;
        chk({4'h0, serial_out_pin, serial_out_enable, xck_out_enable, data_empty_flag, tx_complete_flag}, 9'h012);
        @(posedge clk);
        reset_n <= 1'b1;
        baud_low_write <= 1'b1;
        @(posedge clk);
        baud_low_write <= 1'b0;
        s_formats();
        s_double();
        s_b2b();
        s_hold();
        s_break();
        s_master();
        s_slave();
        wrap_up();
    end
endmodule

// *** usart_baud_gen.v ***
// Baud rate down-counter producing one tick each time it reaches zero, except when a low-byte write lands then
`include "usart_map.vh"
module usart_baud_gen #(
    parameter DIV_W = `USART_DIV_W
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             clk_en,
    input  wire [DIV_W-1:0] baud_divisor,
    input  wire             baud_low_write,
    output reg              tick_q
);

    reg [DIV_W-1:0] count_q;

    // ***************************************************
    // Down-counter
    // ***************************************************
    // Reload on zero or low-byte write; tick marks each zero that no low-byte write coincides with
    always @(posedge clk) begin
        if (!reset_n) begin
            count_q <= `USART_DIV_RST;
            tick_q  <= 1'b0;
        end else if (clk_en) begin
            tick_q <= (count_q == {DIV_W{1'b0}}) && !baud_low_write;
            if (baud_low_write || count_q == {DIV_W{1'b0}}) begin
                count_q <= baud_divisor;
            end else begin
                count_q <= count_q - 1'b1;
            end
        end
    end

endmodule

// *** usart_map.vh ***
// Constants for the serial port clocking, frame format and transmit path
`ifndef USART_MAP_VH
`define USART_MAP_VH

// Baud divisor width and reset value
`define USART_DIV_W        12
`define USART_DIV_RST      12'h000

// Samples per bit in async modes
`define USART_SPB_NORMAL   5'h10
`define USART_SPB_DOUBLE   5'h08

// Character size codes
`define USART_CSZ_NINE     3'h7
`define USART_CSZ_BASE     4'h5
`define USART_CSZ_EIGHT    4'h8

// Parity mode field bit positions
`define USART_PAR_EN_POS   1
`define USART_PAR_ODD_POS  0

// Frame shape
`define USART_FRAME_W      13
`define USART_CNT_W        4

// Line and flag reset values
`define USART_LINE_IDLE    1'h1
`define USART_FLAG_RST     1'h0
`define USART_EMPTY_RST    1'h1

`endif

// *** usart_tx_checker.sv ***
// Property checker for the serial port clocking and transmit block
module usart_tx_checker #(
    parameter DIV_W = 12
) (
    input wire logic             clk, reset_n, clk_en, sync_mode_select, double_speed_bit,
    input wire logic             xck_direction_bit, clock_polarity_bit, stop_bit_select, tx_enable_bit,
    input wire logic             tx_ninth_bit, baud_low_write, data_write, tx_complete_clear,
    input wire logic             serial_in_pin, xck_in, serial_out_pin, serial_out_enable, xck_out,
    input wire logic             xck_out_enable, data_empty_flag, tx_complete_flag, rx_complete_pulse,
    input wire logic             frame_error_flag, parity_error_flag,
    input wire logic [2:0]       char_size_field,
    input wire logic [1:0]       parity_mode_field,
    input wire logic [DIV_W-1:0] baud_divisor,
    input wire logic [7:0]       data_in,
    input wire logic [8:0]       rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    wire master = sync_mode_select && xck_direction_bit;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Registered outputs, so mode checks wait one cycle after the inputs settle
    AST_EMPTY_ON_WRITE: assert property (clk_en && data_write |=> !data_empty_flag)
        else $error("buffer not full after write");
    AST_TAKE_PIN: assert property (clk_en && data_write && tx_enable_bit |=> serial_out_enable)
        else $error("pin not taken");
    AST_LINE_IDLE: assert property ($rose(tx_complete_flag) |-> serial_out_pin && data_empty_flag)
        else $error("line not idle at completion");
    AST_START_MOVE: assert property ($rose(data_empty_flag) |-> !serial_out_pin && serial_out_enable)
        else $error("buffer moved without start bit");
    AST_MASTER_DRIVES: assert property ((clk_en && master) [*2] |-> xck_out_enable)
        else $error("master clock not driven");
    AST_SLAVE_RELEASES: assert property ((clk_en && !master) [*2] |-> !xck_out_enable)
        else $error("clock driven outside master");
    AST_IDLE_LEVEL: assert property ((clk_en && !master && $stable(clock_polarity_bit)) [*2]
        |-> xck_out == clock_polarity_bit)
        else $error("idle clock level wrong");
    AST_CHANGE_EDGE: assert property (xck_out_enable && serial_out_enable && $changed(serial_out_pin)
        |-> $changed(xck_out) && xck_out != clock_polarity_bit)
        else $error("data changed off the change edge");
    AST_MASTER_RATE: assert property (xck_out_enable && clk_en && $changed(xck_out)
        && baud_divisor == 12'h003 |=> ($stable(xck_out) || $changed(clock_polarity_bit) || !master) [*3])
        else $error("master clock too fast");
    cover property (master && data_write);
    cover property ($rose(frame_error_flag));
    cover property (double_speed_bit && $rose(tx_complete_flag));
endmodule
bind usart_tx_clocking usart_tx_checker #(.DIV_W(DIV_W)) u_chk (.*);

// *** usart_tx_clocking.v ***
// Serial port top: clock generation, frame transmitter and frame receiver
`include "usart_map.vh"
module usart_tx_clocking #(
    parameter DIV_W = `USART_DIV_W
) (
    input  wire             clk,
    input  wire             reset_n,
    input  wire             clk_en,
    input  wire             sync_mode_select,
    input  wire             double_speed_bit,
    input  wire             xck_direction_bit,
    input  wire             clock_polarity_bit,
    input  wire [2:0]       char_size_field,
    input  wire [1:0]       parity_mode_field,
    input  wire             stop_bit_select,
    input  wire             tx_enable_bit,
    input  wire             tx_ninth_bit,
    input  wire [DIV_W-1:0] baud_divisor,
    input  wire             baud_low_write,
    input  wire             data_write,
    input  wire [7:0]       data_in,
    input  wire             tx_complete_clear,
    input  wire             serial_in_pin,
    input  wire             xck_in,
    output reg              serial_out_pin,
    output reg              serial_out_enable,
    output reg              xck_out,
    output reg              xck_out_enable,
    output reg              data_empty_flag,
    output reg              tx_complete_flag,
    output reg  [8:0]       rx_data,
    output reg              rx_complete_pulse,
    output reg              frame_error_flag,
    output reg              parity_error_flag
);

    // ***************************************************
    // Clock generation
    // ***************************************************
    wire                    baud_tick;
    wire                    master_sync;
    wire                    slave_sync;
    wire                    fast_async;
    reg                     xck_sync1_q;
    reg                     xck_sync2_q;
    reg                     xck_prev_q;
    reg                     xck_int_q;
    reg  [3:0]              tx_pre_q;
    reg                     rise_ev;
    reg                     fall_ev;
    wire                    change_ev;
    wire                    sample_ev;
    wire [4:0]              spb;
    wire                    tx_bit_tick;

    usart_baud_gen #(
        .DIV_W          (DIV_W)
    ) u_baud (
        .clk            (clk),
        .reset_n        (reset_n),
        .clk_en         (clk_en),
        .baud_divisor   (baud_divisor),
        .baud_low_write (baud_low_write),
        .tick_q         (baud_tick)
    );

    assign master_sync = sync_mode_select && xck_direction_bit;
    assign slave_sync  = sync_mode_select && !xck_direction_bit;
    // Double speed only counts when asynchronous
    assign fast_async  = double_speed_bit && !sync_mode_select;
    assign spb         = fast_async ? `USART_SPB_DOUBLE : `USART_SPB_NORMAL;

    // Pin synchroniser; first stage feeds only the second
    always @(posedge clk) begin
        if (!reset_n) begin
            xck_sync1_q <= 1'b0;
            xck_sync2_q <= 1'b0;
            xck_prev_q  <= 1'b0;
        end else if (clk_en) begin
            xck_sync1_q <= xck_in;
            xck_sync2_q <= xck_sync1_q;
            xck_prev_q  <= xck_sync2_q;
        end
    end

    // Master clock toggles per baud tick, giving the divide by two
    always @(posedge clk) begin
        if (!reset_n) begin
            xck_int_q <= 1'b0;
        end else if (clk_en) begin
            if (master_sync && baud_tick) begin
                xck_int_q <= !xck_int_q;
            end else if (!master_sync) begin
                xck_int_q <= clock_polarity_bit;
            end
        end
    end

    // Edge events of the transfer clock, from whichever source is active
    always @* begin
        rise_ev = 1'b0;
        fall_ev = 1'b0;
        if (slave_sync) begin
            rise_ev = xck_sync2_q && !xck_prev_q;
            fall_ev = !xck_sync2_q && xck_prev_q;
        end else if (master_sync) begin
            rise_ev = baud_tick && !xck_int_q;
            fall_ev = baud_tick && xck_int_q;
        end
    end

    // Data changes on one edge and is sampled on the other
    assign change_ev = clock_polarity_bit ? fall_ev : rise_ev;
    assign sample_ev = clock_polarity_bit ? rise_ev : fall_ev;

    // Async bit prescaler: divide baud ticks by 16 or 8
    always @(posedge clk) begin
        if (!reset_n) begin
            tx_pre_q <= 4'h0;
        end else if (clk_en && baud_tick) begin
            if ({1'b0, tx_pre_q} >= spb - 5'h01) begin
                tx_pre_q <= 4'h0;
            end else begin
                tx_pre_q <= tx_pre_q + 4'h1;
            end
        end
    end

    assign tx_bit_tick = sync_mode_select ? change_ev :
                         (baud_tick && ({1'b0, tx_pre_q} == spb - 5'h01));

    // ***************************************************
    // Frame format, shared by both directions
    // ***************************************************
    reg  [3:0]              nbits;
    wire                    par_en;
    wire [3:0]              frame_len;

    // Live fields, never latched: a change mid-frame corrupts reception; the shifter holds the sent frame
    always @* begin
        if (char_size_field == `USART_CSZ_NINE) begin
            nbits = 4'h9;
        end else if (char_size_field[2]) begin
            nbits = `USART_CSZ_EIGHT;
        end else begin
            nbits = `USART_CSZ_BASE + {2'b00, char_size_field[1:0]};
        end
    end

    assign par_en    = parity_mode_field[`USART_PAR_EN_POS];
    assign frame_len = nbits + 4'h2 + {3'b000, par_en} + {3'b000, stop_bit_select};

    // ***************************************************
    // Transmitter
    // ***************************************************
    reg  [8:0]                  buf_q;
    reg                         buf_full_q;
    reg  [`USART_FRAME_W-1:0]   shift_q;
    reg  [`USART_CNT_W-1:0]     cnt_q;
    reg                         busy_q;
    reg  [`USART_FRAME_W-1:0]   frame;
    reg                         par_bit;
    integer                     i;
    wire                        load_now;
    wire                        frame_end;

    // Assemble start, data LSB first, parity, then stop ones
    always @* begin
        frame    = {`USART_FRAME_W{1'b1}};
        frame[0] = 1'b0;
        par_bit  = parity_mode_field[`USART_PAR_ODD_POS];
        for (i = 0; i < 9; i = i + 1) begin
            if (i < nbits) begin
                frame[i+1] = buf_q[i];
                par_bit    = par_bit ^ buf_q[i];
            end
        end
        if (par_en) begin
            frame[nbits+4'h1] = par_bit;
        end
    end

    assign frame_end = tx_bit_tick && busy_q && (cnt_q == {`USART_CNT_W{1'b0}});
    // Load when idle or immediately after the last stop bit
    assign load_now  = tx_bit_tick && buf_full_q && tx_enable_bit &&
                       (!busy_q || cnt_q == {`USART_CNT_W{1'b0}});

    // Transmit buffer: a write fills it, a load into the shifter empties it
    always @(posedge clk) begin
        if (!reset_n) begin
            buf_q           <= 9'h000;
            buf_full_q      <= 1'b0;
            data_empty_flag <= `USART_EMPTY_RST;
        end else if (clk_en) begin
            if (data_write) begin
                buf_q           <= {tx_ninth_bit, data_in};
                buf_full_q      <= 1'b1;
                data_empty_flag <= 1'b0;
            end else if (load_now) begin
                buf_full_q      <= 1'b0;
                data_empty_flag <= 1'b1;
            end
        end
    end

    // Shift register and line driver
    always @(posedge clk) begin
        if (!reset_n) begin
            shift_q        <= {`USART_FRAME_W{1'b1}};
            cnt_q          <= {`USART_CNT_W{1'b0}};
            busy_q         <= 1'b0;
            serial_out_pin <= `USART_LINE_IDLE;
        end else if (clk_en) begin
            if (load_now) begin
                serial_out_pin <= frame[0];
                shift_q        <= frame >> 1;
                cnt_q          <= frame_len - 4'h1;
                busy_q         <= 1'b1;
            end else if (frame_end) begin
                serial_out_pin <= `USART_LINE_IDLE;
                busy_q         <= 1'b0;
            end else if (tx_bit_tick && busy_q) begin
                serial_out_pin <= shift_q[0];
                shift_q        <= {1'b1, shift_q[`USART_FRAME_W-1:1]};
                cnt_q          <= cnt_q - 1'b1;
            end
        end
    end

    // Complete flag: set beats a clear in the same cycle
    always @(posedge clk) begin
        if (!reset_n) begin
            tx_complete_flag <= `USART_FLAG_RST;
        end else if (clk_en) begin
            if (frame_end && !load_now) begin
                tx_complete_flag <= 1'b1;
            end else if (tx_complete_clear) begin
                tx_complete_flag <= 1'b0;
            end
        end
    end

    // Pin takeover; disabling waits until nothing is left to send
    always @(posedge clk) begin
        if (!reset_n) begin
            serial_out_enable <= 1'b0;
            xck_out           <= 1'b0;
            xck_out_enable    <= 1'b0;
        end else if (clk_en) begin
            serial_out_enable <= tx_enable_bit || busy_q || buf_full_q;
            xck_out           <= master_sync ? (xck_int_q ^ baud_tick) : clock_polarity_bit;
            xck_out_enable    <= master_sync;
        end
    end

    // ***************************************************
    // Receiver
    // ***************************************************
    reg                     rx_busy_q;
    reg  [3:0]              rx_samp_q;
    reg  [3:0]              rx_idx_q;
    reg  [8:0]              rx_shift_q;
    reg                     rx_par_q;
    wire                    rx_sample;
    wire [3:0]              rx_half;
    wire [3:0]              rx_stop_idx;

    assign rx_half     = fast_async ? 4'h3 : 4'h7;
    assign rx_stop_idx = nbits + 4'h1 + {3'b000, par_en};
    assign rx_sample   = sync_mode_select ? sample_ev :
                         (baud_tick && rx_busy_q && rx_samp_q == 4'h0);

    // Start detect, mid-bit sampling, first stop check only
    always @(posedge clk) begin
        if (!reset_n) begin
            rx_busy_q         <= 1'b0;
            rx_samp_q         <= 4'h0;
            rx_idx_q          <= 4'h0;
            rx_shift_q        <= 9'h000;
            rx_par_q          <= 1'b0;
            rx_data           <= 9'h000;
            rx_complete_pulse <= 1'b0;
            frame_error_flag  <= `USART_FLAG_RST;
            parity_error_flag <= `USART_FLAG_RST;
        end else if (clk_en) begin
            rx_complete_pulse <= 1'b0;
            if (!rx_busy_q) begin
                if (sync_mode_select && sample_ev && !serial_in_pin) begin
                    rx_busy_q <= 1'b1;
                    rx_idx_q  <= 4'h1;
                    rx_par_q  <= parity_mode_field[`USART_PAR_ODD_POS];
                end else if (!sync_mode_select && baud_tick && !serial_in_pin) begin
                    rx_busy_q <= 1'b1;
                    rx_samp_q <= rx_half;
                    rx_idx_q  <= 4'h0;
                    rx_par_q  <= parity_mode_field[`USART_PAR_ODD_POS];
                end
            end else begin
                if (!sync_mode_select && baud_tick) begin
                    rx_samp_q <= (rx_samp_q == 4'h0) ? spb[3:0] - 4'h1 : rx_samp_q - 4'h1;
                end
                if (rx_sample) begin
                    rx_idx_q <= rx_idx_q + 4'h1;
                    if (rx_idx_q == 4'h0) begin
                        rx_busy_q <= !serial_in_pin;
                    end else if (rx_idx_q <= nbits) begin
                        rx_shift_q <= {serial_in_pin, rx_shift_q[8:1]};
                        rx_par_q   <= rx_par_q ^ serial_in_pin;
                    end else if (rx_idx_q < rx_stop_idx) begin
                        parity_error_flag <= rx_par_q ^ serial_in_pin;
                    end else begin
                        rx_busy_q         <= 1'b0;
                        rx_data           <= rx_shift_q >> (4'h9 - nbits);
                        rx_complete_pulse <= 1'b1;
                        frame_error_flag  <= !serial_in_pin;
                        if (!par_en) begin
                            parity_error_flag <= 1'b0;
                        end
                    end
                end
            end
        end
    end

endmodule
